// [design/pwm_gen_map.svh]
// Register map, field positions and reset values of the pulse-width generator
`ifndef PWM_GEN_MAP_SVH
`define PWM_GEN_MAP_SVH
`define PWM_BASE_FIRST 32'h0000_5800
`define PWM_BASE_LAST 32'h0000_5870
`define PWM_BASE_STEP 32'h0000_0010
`define PWM_INSTANCES 8
`define PWM_OFF_HIGH 4'h0
`define PWM_OFF_LOW 4'h4
`define PWM_OFF_CFG 4'h8
`define PWM_HIGH_RESET 16'h0000
`define PWM_LOW_RESET 16'hffff
`define PWM_CFG_RESET 7'h00
`define PWM_CFG_ENABLE 0
`define PWM_CFG_CLKSEL 1
`define PWM_CFG_INVERT 2
`define PWM_CFG_DIV_LSB 3
`define PWM_CFG_DIV_MSB 6
`endif

// [design/pwm_gen_pkg.sv]
// Types of the pulse-width generator
`default_nettype none
package pwm_gen_pkg;
  typedef enum logic [1:0] {
    ph_off = 2'b01,
    ph_on = 2'b10
  } phase_t;

  typedef struct packed {
    logic [15:0] high_phase_count;
    logic [15:0] low_phase_count;
    logic [6:0] config_bits;
    logic [15:0] live_high;
    logic [15:0] live_low;
    logic [15:0] down;
    logic [3:0] div;
    phase_t phase;
    logic pwm_out;
    logic [31:0] rdata;
    logic fast_s1;
    logic fast_s2;
    logic fast_s3;
    logic slow_s1;
    logic slow_s2;
    logic slow_s3;
  } state_t;
endpackage : pwm_gen_pkg
`default_nettype wire

// [design/fan_led_pwm_generator.sv]
// Eight pulse-width generators behind the internal register bus
//
// Function
// - Output toggles, holds fully high, or holds fully low.
// - Count tick is the selected source clock, divided by the pre-divider field plus one.
// - Fast source is the 48 MHz oscillator, slow source the 100 kHz clock.
// - High-phase count n gives n+1 ticks in the on state.
// - Low-phase count n gives n+1 ticks in the off state.
// - Period is (div+1) times the sum of both phases plus two.
// - On fraction is (high+1) over (high+1)+(low+1).
// - High count zero with low count nonzero holds output off.
// - Low count zero holds output on.
// - Eight instances at 0x5800 to 0x5870, stride 0x10, three registers each.
// - Pre-divider divides the source by its value plus one.
// - Invert bit set makes the on state active low.
// - Clock select set picks the slow source, clear the fast one.
// - Enable clear resets counters, phase off, output inactive; counts stay accessible.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_gen_map.svh"

module fan_led_pwm_generator
  import pwm_gen_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_en,
  // Source clocks, foreign to this domain
  input wire logic fast_clock_input,
  input wire logic slow_clock_input,
  // Register bus
  input wire logic [31:0] addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  // Outputs to the pins
  output logic [7:0] pwm_output
);
  // ====================================================================
  // Address decode
  logic hit;
  logic [2:0] sel;
  logic [3:0] off;
  always_comb begin
    hit = (addr >= `PWM_BASE_FIRST) && (addr <= (`PWM_BASE_LAST + 32'h0000_000c));
    sel = addr[6:4];
    off = addr[3:0];
  end

  logic [`PWM_INSTANCES-1:0][31:0] rd_word;

  // ====================================================================
  // Generator instances
  genvar g;
  generate
    for (g = 0; g < `PWM_INSTANCES; g++) begin : gen_pwm
      state_t st;
      state_t next_st;
      logic me;
      logic tick;
      logic src_edge;
      logic [3:0] div_max;
      logic en;
      logic inv;

      always_comb begin
        next_st = st;
        me = hit && (sel == 3'(g));
        en = st.config_bits[`PWM_CFG_ENABLE];
        inv = st.config_bits[`PWM_CFG_INVERT];
        div_max = st.config_bits[`PWM_CFG_DIV_MSB:`PWM_CFG_DIV_LSB];
        // ====================================================================
        // Two-stage synchronisers, third stage only for edge detection
        next_st.fast_s1 = fast_clock_input;
        next_st.fast_s2 = st.fast_s1;
        next_st.fast_s3 = st.fast_s2;
        next_st.slow_s1 = slow_clock_input;
        next_st.slow_s2 = st.slow_s1;
        next_st.slow_s3 = st.slow_s2;
        // Fast source above half of this clock cannot be sampled faithfully
        if (st.config_bits[`PWM_CFG_CLKSEL]) begin
          src_edge = st.slow_s2 && !st.slow_s3;
        end else begin
          src_edge = st.fast_s2 && !st.fast_s3;
        end
        tick = 1'b0;

        // ====================================================================
        // Register writes
        if (me && wr_en) begin
          case (off)
            `PWM_OFF_HIGH: next_st.high_phase_count = wdata[15:0];
            `PWM_OFF_LOW: next_st.low_phase_count = wdata[15:0];
            `PWM_OFF_CFG: next_st.config_bits = wdata[6:0];
            default: ;
          endcase
        end

        // ====================================================================
        // Phase counter
        // Disable clears the counters but keeps the counts live for reload
        if (!en) begin
          next_st.down = 16'h0000;
          next_st.div = 4'h0;
          next_st.phase = ph_off;
          next_st.live_high = st.high_phase_count;
          next_st.live_low = st.low_phase_count;
          next_st.pwm_out = inv;
        end else begin
          if (src_edge) begin
            // Compare with >= so a smaller divider written mid-count takes at once
            if (st.div >= div_max) begin
              next_st.div = 4'h0;
              tick = 1'b1;
            end else begin
              next_st.div = st.div + 4'h1;
            end
          end
          if (tick) begin
            case (st.phase)
              ph_on: begin
                if (st.down == 16'h0000) begin
                  next_st.phase = ph_off;
                  next_st.down = st.live_low;
                end else begin
                  next_st.down = st.down - 16'h0001;
                end
              end
              ph_off: begin
                if (st.down == 16'h0000) begin
                  // Period boundary: latch new counts
                  next_st.live_high = st.high_phase_count;
                  next_st.live_low = st.low_phase_count;
                  next_st.phase = ph_on;
                  next_st.down = st.high_phase_count;
                end else begin
                  next_st.down = st.down - 16'h0001;
                end
              end
              default: begin
                next_st.phase = ph_off;
                next_st.down = 16'h0000;
              end
            endcase
          end

          // ====================================================================
          // Output level
          // Full on wins when both counts are zero
          if (st.live_low == 16'h0000) begin
            next_st.pwm_out = !inv;
          end else if (st.live_high == 16'h0000) begin
            next_st.pwm_out = inv;
          end else if (st.phase == ph_on) begin
            next_st.pwm_out = !inv;
          end else begin
            next_st.pwm_out = inv;
          end
        end

        // ====================================================================
        // Read word
        // Built from next_st so a read beside a write returns the new value
        next_st.rdata = 32'h0000_0000;
        case (off)
          `PWM_OFF_HIGH: next_st.rdata = {16'h0000, next_st.high_phase_count};
          `PWM_OFF_LOW: next_st.rdata = {16'h0000, next_st.low_phase_count};
          `PWM_OFF_CFG: next_st.rdata = {25'h000_0000, next_st.config_bits};
          default: ;
        endcase
        if (!(me && rd_en)) begin
          next_st.rdata = 32'h0000_0000;
        end
      end

      // ====================================================================
      // State register
      // Clock enable low holds every field, synchronisers included
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          st <= '{
            high_phase_count: `PWM_HIGH_RESET,
            low_phase_count: `PWM_LOW_RESET,
            config_bits: `PWM_CFG_RESET,
            live_high: `PWM_HIGH_RESET,
            live_low: `PWM_LOW_RESET,
            down: 16'h0000,
            div: 4'h0,
            phase: ph_off,
            pwm_out: 1'b0,
            rdata: 32'h0000_0000,
            fast_s1: 1'b0,
            fast_s2: 1'b0,
            fast_s3: 1'b0,
            slow_s1: 1'b0,
            slow_s2: 1'b0,
            slow_s3: 1'b0
          };
        end else if (clock_en) begin
          st <= next_st;
        end
      end

      assign rd_word[g] = st.rdata;
      assign pwm_output[g] = st.pwm_out;
    end
  endgenerate

  // ====================================================================
  // Read mux: non-selected instances return zero
  always_comb begin
    rdata = 32'h0000_0000;
    for (int i = 0; i < `PWM_INSTANCES; i++) begin
      rdata = rdata | rd_word[i];
    end
  end
endmodule : fan_led_pwm_generator
`default_nettype wire

// [test/pin_load.sv]
// Pin load that measures phase lengths in source edges
`timescale 1ns/10ps
`default_nettype none
// ====
// Load
module pin_load (
  input wire logic src,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic [15:0] run = 16'h0001;
  logic last = 1'b0;
  // Edges of the generator's own source, so the count is exact
  always @(posedge src) begin
    if (pin !== last) begin
      if (last)
        hi_len <= run;
      else
        lo_len <= run;
      run <= 16'h0001;
      last <= pin;
    end else
      run <= run + 16'h0001;
  end
endmodule : pin_load
`default_nettype wire

// [test/pwm_gen_properties.sv]
// Port checker of the pulse-width generator
`timescale 1ns/10ps
`default_nettype none
// ====
// Properties
module pwm_gen_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_en,
  // Source clocks
  input wire logic fast_clock_input,
  input wire logic slow_clock_input,
  // Register bus
  input wire logic [31:0] addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  // Pins
  input wire logic [7:0] pwm_output
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
    else $error("rdata not idle");
  a_unmapped_zero: assert property (rd_en && addr[31:7] != 25'h0b0 |=> rdata == 32'h0000_0000)
    else $error("unmapped read");
  a_hole_zero: assert property (rd_en && addr[3:0] == 4'hc |=> rdata == 32'h0000_0000)
    else $error("offset c read");
  a_count_reserved: assert property (rd_en && !addr[3] |=> rdata[31:16] == 16'h0000)
    else $error("count upper bits");
  a_config_reserved: assert property (rd_en && addr[3:0] == 4'h8 |=> rdata[31:7] == 25'h000_0000)
    else $error("config upper bits");
  a_quiet_stable: assert property ((!wr_en && $stable(fast_clock_input) && $stable(slow_clock_input))[*8]
    |=> $stable(pwm_output))
    else $error("output moved without tick");
  a_disabled_level: assert property (wr_en && addr == 32'h0000_5808 && !wdata[0] ##1 !wr_en
    |=> pwm_output[0] == $past(wdata[2], 2))
    else $error("disabled level");
  a_write_through: assert property (wr_en && rd_en && addr[31:7] == 25'h0b0 && !addr[3]
    |=> rdata == {16'h0000, $past(wdata[15:0])})
    else $error("same cycle read");
endmodule : pwm_gen_properties
bind fan_led_pwm_generator pwm_gen_properties props (.clock(clock), .rstn(rstn), .clock_en(clock_en),
  .fast_clock_input(fast_clock_input), .slow_clock_input(slow_clock_input), .rd_en(rd_en),
  .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata), .pwm_output(pwm_output));
`default_nettype wire

// [test/tb.sv]
// Testbench of the pulse-width generator
`timescale 1ns/10ps
`default_nettype none
// ====
// Bench
module tb;
  logic clock = 1'b0, rstn = 1'b0, fast_clock_input = 1'b0, slow_clock_input = 1'b0;
  logic fast_run = 1'b1, src_sel = 1'b0, rd_en = 1'b0, wr_en = 1'b0, clock_en = 1'b1;
  logic [31:0] addr = 32'h0000_0000, wdata = 32'h0000_0000, rdata, got;
  logic [31:0] cfg_a = 32'h0000_5808;
  logic [7:0] pwm_output;
  logic [15:0] hi_len, lo_len;
  int err_total = 0, checks_done = 0, cyc = 0;
  always #4 clock = ~clock;
  // Fast source pauses in slow runs so the quiet window is reached
  always #10.42 fast_clock_input = fast_run ? ~fast_clock_input : fast_clock_input;
  always #5000 slow_clock_input = ~slow_clock_input;
  fan_led_pwm_generator dut (.clock(clock), .rstn(rstn), .clock_en(clock_en), .fast_clock_input(fast_clock_input),
    .slow_clock_input(slow_clock_input), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata),
    .rdata(rdata), .pwm_output(pwm_output));
  pin_load load (.src(src_sel ? slow_clock_input : fast_clock_input), .pin(pwm_output[0]),
    .hi_len(hi_len), .lo_len(lo_len));
  task results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task cmp(input string what, input logic [31:0] e, input logic [31:0] seen);
    checks_done++;
    if (e !== seen) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, seen);
    end
  endtask : cmp
  task wt(input int n);
    repeat (n) @(negedge clock);
  endtask : wt
  // Any cycle off the expected level counts, so a stray pulse is caught
  task hold(input logic e);
    int bad;
    bad = 0;
    repeat (200) begin
      @(negedge clock);
      if (pwm_output[0] !== e) begin
        bad++;
      end
    end
    cmp("held_level", 32'h0000_0000, 32'(bad));
  endtask : hold
  task acc(input logic [31:0] a, d, input logic w, r);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr_en = w;
    rd_en = r;
    @(negedge clock);
    wr_en = 1'b0;
    rd_en = 1'b0;
    got = rdata;
  endtask : acc
  task rd(input logic [31:0] a, e);
    acc(a, 32'h0000_0000, 1'b0, 1'b1);
    cmp("rdata", e, got);
  endtask : rd
  // Disable first so the new counts load at once
  task setup(input logic [31:0] h, l, c, input logic s);
    acc(cfg_a, 32'h0000_0000, 1'b1, 1'b0);
    acc(32'h0000_5800, h, 1'b1, 1'b0);
    acc(32'h0000_5804, l, 1'b1, 1'b0);
    acc(cfg_a, c, 1'b1, 1'b0);
    src_sel = s;
    fast_run = !s;
    wt(s ? 14000 : 400);
  endtask : setup
  task run(input logic [31:0] h, l, c, eh, el, input logic s);
    setup(h, l, c, s);
    cmp("on_len", eh, {16'h0000, hi_len});
    cmp("off_len", el, {16'h0000, lo_len});
  endtask : run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      results();
    end
  end
  initial begin
    wt(10);
    rstn = 1'b1;
    for (int g = 0; g < 8; g++) begin
      rd(32'h0000_5800 + 32'(g * 16), 32'h0000_0000);
      rd(32'h0000_5804 + 32'(g * 16), 32'h0000_ffff);
      rd(32'h0000_5808 + 32'(g * 16), 32'h0000_0000);
    end
    rd(32'h0000_5880, 32'h0000_0000);
    rd(32'h0000_580c, 32'h0000_0000);
    acc(32'h0000_5814, 32'h1234_5678, 1'b1, 1'b1);
    cmp("rdata", 32'h0000_5678, got);
    acc(32'h0000_5818, 32'hffff_fffe, 1'b1, 1'b0);
    rd(32'h0000_5818, 32'h0000_007e);
    acc(cfg_a, 32'h0000_0004, 1'b1, 1'b0);
    wt(1);
    cmp("pin", 32'h0000_0001, {31'h0, pwm_output[0]});
    run(32'h0000_0002, 32'h0000_0004, 32'h0000_0001, 32'h0000_0003, 32'h0000_0005, 1'b0);
    // New counts while running must reach the pin at a period boundary
    acc(32'h0000_5800, 32'h0000_0006, 1'b1, 1'b0);
    acc(32'h0000_5804, 32'h0000_0008, 1'b1, 1'b0);
    wt(400);
    cmp("on_len", 32'h0000_0007, {16'h0000, hi_len});
    cmp("off_len", 32'h0000_0009, {16'h0000, lo_len});
    run(32'h0000_0002, 32'h0000_0004, 32'h0000_0011, 32'h0000_0009, 32'h0000_000f, 1'b0);
    run(32'h0000_0002, 32'h0000_0004, 32'h0000_0015, 32'h0000_000f, 32'h0000_0009, 1'b0);
    run(32'h0000_0001, 32'h0000_0002, 32'h0000_0003, 32'h0000_0002, 32'h0000_0003, 1'b1);
    setup(32'h0000_0003, 32'h0000_0000, 32'h0000_0001, 1'b0);
    cmp("pin", 32'h0000_0001, {31'h0, pwm_output[0]});
    hold(1'b1);
    setup(32'h0000_0000, 32'h0000_0005, 32'h0000_0001, 1'b0);
    cmp("pin", 32'h0000_0000, {31'h0, pwm_output[0]});
    hold(1'b0);
    // Frozen clock enable must drop a write
    clock_en = 1'b0;
    acc(32'h0000_5820, 32'h0000_1234, 1'b1, 1'b0);
    clock_en = 1'b1;
    rd(32'h0000_5820, 32'h0000_0000);
    results();
  end
endmodule : tb
`default_nettype wire
